/* design/ssi_link_init.sv */
/*
 * ssi_link_init: four lane lock machines, one column deskew machine and
 * the single-lane initialization machine, with a Wishbone register slave.
 * Assumes the lane decoder presents per-lane flags that are stable around
 * the rising edge of the sampled code-group clock, at most mclk/4.
 */
`timescale 1ns/1ps
module ssi_link_init (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        cg_clk,
    input  wire logic [3:0]  lane_k285,
    input  wire logic [3:0]  lane_invalid,
    input  wire logic [3:0]  lane_align,
    input  wire logic [3:0]  input_present,
    input  wire logic        tx_busy,
    output logic             lane02_drv_oe,
    output logic             lane13_drv_oe,
    output logic             link_up,
    output logic             receive_lane2,
    output logic             tx_send_idle,
    output logic             tx_grant,
    output logic [3:0]       lane_realign_en,
    output logic             deskew_adjust_en,
    output logic             column_mismatch
);

    typedef struct packed {
        ssi_pkg::ssi_pins_s      s1;
        ssi_pkg::ssi_pins_s      s2;
        logic                    clk_d;
        ssi_pkg::ssi_lane_s [3:0] lanes;
        ssi_pkg::ssi_dsk_s       dsk;
        ssi_pkg::ssi_init_e      init;
        logic [10:0]             qcnt;
        logic                    qdone;
        logic                    reinit_req;
        logic                    force_lane2;
        logic                    lane2;
        logic                    ack;
        logic [31:0]             rdata;
        logic                    oe02;
        logic                    oe13;
        logic                    up;
        logic                    idle;
        logic                    grant;
        logic [3:0]              realign;
        logic                    dsk_adj;
    } ssi_state_s;

    ssi_state_s st_reg;
    ssi_state_s st_next;

    function automatic ssi_pkg::ssi_lane_s lane_step(
        input ssi_pkg::ssi_lane_s l,
        input logic               k,
        input logic               inv,
        input logic               present
    );
        ssi_pkg::ssi_lane_s n;
        n = l;
        unique case (l.st)
            ssi_pkg::LN_UNLOCKED: begin
                n.kcnt   = 7'h00;
                n.locked = 1'b0;
                if (k && present && !inv) begin
                    n.st = ssi_pkg::LN_ACQ1;
                end
            end
            ssi_pkg::LN_ACQ1, ssi_pkg::LN_ACQ2: begin
                if (inv) begin
                    n.st   = ssi_pkg::LN_UNLOCKED;
                    n.kcnt = 7'h00;
                end else if (k) begin
                    if (l.kcnt == ssi_pkg::K_FURTHER - 7'h01) begin
                        n.st     = ssi_pkg::LN_LOCKED;
                        n.locked = 1'b1;
                        n.icnt   = 2'h0;
                    end else begin
                        n.kcnt = l.kcnt + 7'h01;
                        n.st   = ssi_pkg::LN_ACQ2;
                    end
                end else begin
                    n.st = ssi_pkg::LN_ACQ1;
                end
            end
            ssi_pkg::LN_LOCKED: begin
                n.locked = 1'b1;
                n.icnt   = 2'h0;
                if (inv) begin
                    n.st   = ssi_pkg::LN_ERR1;
                    n.icnt = 2'h1;
                    n.vcnt = 8'h00;
                end
            end
            default: begin
                // error tracking: state encodes invalid count and run phase
                if (inv) begin
                    n.vcnt = 8'h00;
                    if (l.icnt == ssi_pkg::I_LIMIT - 2'h1) begin
                        n.st     = ssi_pkg::LN_UNLOCKED;
                        n.icnt   = 2'h0;
                        n.locked = 1'b0;
                        n.kcnt   = 7'h00;
                    end else begin
                        n.icnt = l.icnt + 2'h1;
                        n.st   = ssi_pkg::LN_ERR3;
                    end
                end else if (l.vcnt == ssi_pkg::V_RUN - 8'h01) begin
                    n.vcnt = 8'h00;
                    n.icnt = l.icnt - 2'h1;
                    if (l.icnt == 2'h1) begin
                        n.st = ssi_pkg::LN_LOCKED;
                    end else begin
                        n.st = ssi_pkg::LN_ERR1;
                    end
                end else begin
                    n.vcnt = l.vcnt + 8'h01;
                    n.st   = (l.icnt == 2'h1) ? ssi_pkg::LN_ERR2 : ssi_pkg::LN_ERR4;
                end
            end
        endcase
        return n;
    endfunction

    logic       cg_edge;
    logic [3:0] locked_v;
    logic       all_locked;
    logic       col_all_a;
    logic       col_some_a;
    logic       sel_locked;
    logic       wb_req;

    always_comb begin
        st_next    = st_reg;
        st_next.s1 = '{k: lane_k285, inv: lane_invalid, a: lane_align,
                       present: input_present, clk: cg_clk};
        st_next.s2    = st_reg.s1;
        st_next.clk_d = st_reg.s2.clk;
        // only the second stage is looked at; the first may be metastable
        cg_edge = st_reg.s2.clk && !st_reg.clk_d;

        for (int i = 0; i < 4; i++) begin
            locked_v[i] = st_reg.lanes[i].locked;
            if (cg_edge) begin
                st_next.lanes[i] = lane_step(st_reg.lanes[i], st_reg.s2.k[i],
                                             st_reg.s2.inv[i],
                                             st_reg.s2.present[i]);
            end
            // one errored code-group never unlocks a lane in LN_LOCKED, so never realigns it; in LN_ACQ1 or LN_ACQ2 it does
            st_next.realign[i] = (st_next.lanes[i].st == ssi_pkg::LN_UNLOCKED);
        end
        all_locked = &locked_v;

        col_all_a  = &st_reg.s2.a;
        col_some_a = |st_reg.s2.a && !col_all_a;

        // single deskew machine, stepped once per column
        if (cg_edge) begin
            st_next.dsk.mismatch = col_some_a;
            unique case (st_reg.dsk.st)
                ssi_pkg::DK_NA: begin
                    st_next.dsk.acnt     = 3'h0;
                    st_next.dsk.deskewed = 1'b0;
                    if (all_locked && col_all_a) begin
                        st_next.dsk.st   = ssi_pkg::DK_NA1;
                        st_next.dsk.acnt = 3'h1;
                    end
                end
                ssi_pkg::DK_NA1, ssi_pkg::DK_NA2: begin
                    if (col_some_a || !all_locked) begin
                        st_next.dsk.st   = ssi_pkg::DK_NA;
                        st_next.dsk.acnt = 3'h0;
                    end else if (col_all_a) begin
                        if (st_reg.dsk.acnt == ssi_pkg::A_COLUMNS - 3'h1) begin
                            st_next.dsk.st       = ssi_pkg::DK_AL;
                            st_next.dsk.deskewed = 1'b1;
                            st_next.dsk.mcnt     = 2'h0;
                        end else begin
                            st_next.dsk.acnt = st_reg.dsk.acnt + 3'h1;
                            st_next.dsk.st   = ssi_pkg::DK_NA2;
                        end
                    end
                end
                ssi_pkg::DK_AL: begin
                    st_next.dsk.deskewed = 1'b1;
                    st_next.dsk.mcnt     = 2'h0;
                    if (!all_locked) begin
                        // lost lane lock clears deskewed one column late, since all_locked is taken from the registered lane state
                        st_next.dsk.st       = ssi_pkg::DK_NA;
                        st_next.dsk.deskewed = 1'b0;
                    end else if (col_some_a) begin
                        st_next.dsk.st   = ssi_pkg::DK_AL1;
                        st_next.dsk.mcnt = 2'h1;
                        st_next.dsk.acnt = 3'h0;
                    end
                end
                ssi_pkg::DK_AL1, ssi_pkg::DK_AL2, ssi_pkg::DK_AL3: begin
                    if (col_some_a || !all_locked) begin
                        st_next.dsk.st       = ssi_pkg::DK_NA;
                        st_next.dsk.deskewed = 1'b0;
                        st_next.dsk.acnt     = 3'h0;
                    end else if (col_all_a) begin
                        if (st_reg.dsk.acnt == ssi_pkg::A_COLUMNS - 3'h1) begin
                            st_next.dsk.st   = ssi_pkg::DK_AL;
                            st_next.dsk.mcnt = 2'h0;
                        end else begin
                            st_next.dsk.acnt = st_reg.dsk.acnt + 3'h1;
                            st_next.dsk.st   = (st_reg.dsk.st == ssi_pkg::DK_AL1) ?
                                               ssi_pkg::DK_AL2 : ssi_pkg::DK_AL3;
                        end
                    end
                end
                default: begin
                    st_next.dsk.st = ssi_pkg::DK_NA;
                end
            endcase
        end
        st_next.dsk_adj = (st_next.dsk.st == ssi_pkg::DK_NA);

        // quiet timer runs only while quiet and done is clear; done lasts one cycle and clears here
        st_next.qdone = 1'b0;
        st_next.qcnt  = 11'h000;
        if (st_reg.init == ssi_pkg::IN_QUIET && !st_reg.qdone) begin
            if (st_reg.qcnt == ssi_pkg::QUIET_CYCLES - 11'h001) begin
                st_next.qdone = 1'b1;
            end else begin
                st_next.qcnt = st_reg.qcnt + 11'h001;
            end
        end

        sel_locked = st_reg.force_lane2 ? locked_v[2] : (locked_v[0] | locked_v[2]);
        unique case (st_reg.init)
            ssi_pkg::IN_QUIET: begin
                if (st_reg.qdone) begin
                    st_next.init = ssi_pkg::IN_SEEK;
                end
            end
            ssi_pkg::IN_SEEK: begin
                if (sel_locked) begin
                    st_next.init  = ssi_pkg::IN_ACTIVE;
                    st_next.lane2 = st_reg.force_lane2 || !locked_v[0];
                end
            end
            ssi_pkg::IN_ACTIVE: begin
                if (!locked_v[st_reg.lane2 ? 2 : 0]) begin
                    st_next.init = ssi_pkg::IN_QUIET;
                end
            end
            default: begin
                st_next.init = ssi_pkg::IN_QUIET;
            end
        endcase
        if (st_reg.reinit_req) begin
            st_next.init       = ssi_pkg::IN_QUIET;
            st_next.reinit_req = 1'b0;
            st_next.qcnt       = 11'h000;
            st_next.qdone      = 1'b0;
        end

        // driver off in quiet; lanes 1 and 3 stay off in single-lane use
        st_next.oe02  = (st_next.init != ssi_pkg::IN_QUIET);
        st_next.oe13  = 1'b0;
        st_next.up    = (st_next.init == ssi_pkg::IN_ACTIVE);
        st_next.grant = st_next.up && tx_busy;
        st_next.idle  = !st_next.grant;

        // wishbone slave: one wait state, ack drops after one cycle
        wb_req        = wb_cyc_i && wb_stb_i && !st_reg.ack;
        st_next.ack   = wb_req;
        st_next.rdata = 32'h0000_0000;
        if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ssi_pkg::ADDR_CTRL) begin
            // a set in the cycle the machine clears still lands
            if (wb_dat_i[ssi_pkg::CTRL_REINIT]) begin
                st_next.reinit_req = 1'b1;
            end
            st_next.force_lane2 = wb_dat_i[ssi_pkg::CTRL_LANE2];
        end
        if (wb_req && !wb_we_i) begin
            if (wb_adr_i == ssi_pkg::ADDR_CTRL) begin
                st_next.rdata[ssi_pkg::CTRL_REINIT] = st_reg.reinit_req;
                st_next.rdata[ssi_pkg::CTRL_LANE2]  = st_reg.force_lane2;
            end else if (wb_adr_i == ssi_pkg::ADDR_STATUS) begin
                st_next.rdata[ssi_pkg::ST_LOCKED_LSB +: 4] = locked_v;
                st_next.rdata[ssi_pkg::ST_ALL_LOCKED]      = all_locked;
                st_next.rdata[ssi_pkg::ST_DESKEWED]        = st_reg.dsk.deskewed;
                st_next.rdata[ssi_pkg::ST_MISMATCH]        = st_reg.dsk.mismatch;
                st_next.rdata[ssi_pkg::ST_LINK_UP]         = st_reg.up;
                st_next.rdata[ssi_pkg::ST_INIT_LSB +: 2]   = st_reg.init;
                st_next.rdata[ssi_pkg::ST_LANE2]           = st_reg.lane2;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_reg         <= '0;
            st_reg.idle    <= 1'b1;
            st_reg.realign <= 4'hf;
            st_reg.dsk_adj <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_dat_o         = st_reg.rdata;
    assign wb_ack_o         = st_reg.ack;
    assign lane02_drv_oe    = st_reg.oe02;
    assign lane13_drv_oe    = st_reg.oe13;
    assign link_up          = st_reg.up;
    assign receive_lane2    = st_reg.lane2;
    assign tx_send_idle     = st_reg.idle;
    assign tx_grant         = st_reg.grant;
    assign lane_realign_en  = st_reg.realign;
    assign deskew_adjust_en = st_reg.dsk_adj;
    assign column_mismatch  = st_reg.dsk.mismatch;

endmodule

/* design/ssi_pkg.sv */
/*
 * ssi_pkg: constants, state codes and state structs for the serial link
 * lane lock, column deskew and link bring-up block.
 * Assumes a 10 MHz mclk and a classic Wishbone register bus.
 */
package ssi_pkg;
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_STATUS    = 8'h04;
    localparam int          CTRL_REINIT    = 0;
    localparam int          CTRL_LANE2     = 1;
    localparam int          ST_LOCKED_LSB  = 0;
    localparam int          ST_ALL_LOCKED  = 4;
    localparam int          ST_DESKEWED    = 5;
    localparam int          ST_MISMATCH    = 6;
    localparam int          ST_LINK_UP     = 7;
    localparam int          ST_INIT_LSB    = 8;
    localparam int          ST_LANE2       = 10;
    localparam logic [6:0]  K_FURTHER      = 7'h7f;
    localparam logic [7:0]  V_RUN          = 8'hff;
    localparam logic [1:0]  I_LIMIT        = 2'h3;
    localparam logic [2:0]  A_COLUMNS      = 3'h4;
    localparam int          QUIET_US       = 120;
    localparam int          CLK_MHZ        = 10;
    localparam logic [10:0] QUIET_CYCLES   = 11'(QUIET_US * CLK_MHZ);

    typedef enum logic [2:0] {
        LN_UNLOCKED = 3'h0, LN_ACQ1 = 3'h1, LN_ACQ2 = 3'h2, LN_LOCKED = 3'h3,
        LN_ERR1 = 3'h4, LN_ERR2 = 3'h5, LN_ERR3 = 3'h6, LN_ERR4 = 3'h7
    } ssi_lane_e;

    typedef enum logic [2:0] {
        DK_NA = 3'h0, DK_NA1 = 3'h1, DK_NA2 = 3'h2, DK_AL = 3'h3,
        DK_AL1 = 3'h4, DK_AL2 = 3'h5, DK_AL3 = 3'h6
    } ssi_dsk_e;

    typedef enum logic [1:0] {
        IN_QUIET = 2'h0, IN_SEEK = 2'h1, IN_ACTIVE = 2'h2
    } ssi_init_e;

    typedef struct packed {
        ssi_lane_e  st;
        logic [6:0] kcnt;
        logic [1:0] icnt;
        logic [7:0] vcnt;
        logic       locked;
    } ssi_lane_s;

    typedef struct packed {
        ssi_dsk_e   st;
        logic [2:0] acnt;
        logic [1:0] mcnt;
        logic       deskewed;
        logic       mismatch;
    } ssi_dsk_s;

    typedef struct packed {
        logic [3:0] k;
        logic [3:0] inv;
        logic [3:0] a;
        logic [3:0] present;
        logic       clk;
    } ssi_pins_s;
endpackage

/* verif/ssi_link_init_assertions.sv */
/*
 * ssi_link_init_assertions: timing checks on the bring-up and transmit
 * outputs of ssi_link_init.
 * Assumes one mclk domain, async active-low resetn, bound from the bench.
 */
`timescale 1ns/1ps
module ssi_link_init_assertions (
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        tx_busy,
    input wire logic        lane02_drv_oe,
    input wire logic        lane13_drv_oe,
    input wire logic        link_up,
    input wire logic        receive_lane2,
    input wire logic        tx_send_idle,
    input wire logic        tx_grant
);
    logic [11:0] quiet_cnt;
    // driver-off cycles; saturates so a stuck quiet state still shows
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            quiet_cnt <= 12'h000;
        end else if (lane02_drv_oe) begin
            quiet_cnt <= 12'h000;
        end else if (quiet_cnt != 12'hfff) begin
            quiet_cnt <= quiet_cnt + 12'h001;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    property p_quiet_min;
        $rose(lane02_drv_oe) |-> quiet_cnt >= 12'h4ab;
    endproperty
    a_quiet_min: assert property (p_quiet_min)
        else $error("driver enabled before quiet period ended");
    property p_quiet_max;
        quiet_cnt <= 12'h4ba;
    endproperty
    a_quiet_max: assert property (p_quiet_max)
        else $error("quiet period overran");
    property p_up_from_seek;
        $rose(link_up) |-> $past(lane02_drv_oe);
    endproperty
    a_up_from_seek: assert property (p_up_from_seek)
        else $error("link up without seek");
    property p_grant_cause;
        tx_grant |-> link_up && $past(tx_busy);
    endproperty
    a_grant_cause: assert property (p_grant_cause)
        else $error("transmit granted while link down");
    property p_grant_given;
        link_up && $past(tx_busy) |-> tx_grant;
    endproperty
    a_grant_given: assert property (p_grant_given)
        else $error("transmit not granted while link up");
    property p_idle_fill;
        !tx_grant |-> tx_send_idle && (!link_up || !$past(tx_busy));
    endproperty
    a_idle_fill: assert property (p_idle_fill)
        else $error("gap not filled with idle");
    property p_no_lane13;
        !lane13_drv_oe;
    endproperty
    a_no_lane13: assert property (p_no_lane13)
        else $error("lane 1 and 3 drivers enabled");
    property p_reinit;
        wb_ack_o && wb_we_i && wb_adr_i == ssi_pkg::ADDR_CTRL && wb_sel_i[0] && wb_dat_i[0]
            |-> ##[1:3] (!lane02_drv_oe && !link_up);
    endproperty
    a_reinit: assert property (p_reinit)
        else $error("restart request ignored");
    property p_lane_sel;
        $rose(receive_lane2) |-> $rose(link_up);
    endproperty
    a_lane_sel: assert property (p_lane_sel)
        else $error("input lane changed outside bring-up");
endmodule

/* verif/ssi_peer_model.sv */
/*
 * ssi_peer_model: far-end port seen as per-lane code-group flags and the
 * code-group clock. Assumes the bench commands one column per clock.
 */
`timescale 1ns/1ps
module ssi_peer_model (
    input  wire logic          run,
    input  wire logic [3:0]    k,
    input  wire logic [3:0]    inv,
    input  wire logic [3:0]    a,
    input  wire logic [3:0]    present,
    output ssi_pkg::ssi_pins_s pins
);
    logic live;
    // clock stands still between bursts; lanes then toggle so stale data never looks held
    initial begin
        pins = '0;
        live = 1'b0;
        #37;
        forever begin
            #400;
            if (run && live && !pins.clk) begin
                pins.clk <= 1'b1;
            end else begin
                pins.clk <= 1'b0;
                live <= run;
                pins.k <= run ? k : ~pins.k;
                pins.inv <= run ? inv : ~pins.inv;
                pins.a <= run ? a : ~pins.a;
                pins.present <= run ? present : ~pins.present;
            end
        end
    end
endmodule

/* verif/ssi_link_init_tb.sv */
/*
 * ssi_link_init_tb: bus and link tests for ssi_link_init.
 * Assumes the peer model and the checker are compiled before it.
 */
`timescale 1ns/1ps
module ssi_link_init_tb;
    logic        mclk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tx_busy;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i, lane_realign_en, cmd_k, cmd_inv, cmd_a, cmd_p;
    logic [31:0] wb_dat_i, wb_dat_o, rdata;
    logic        lane02_drv_oe, lane13_drv_oe, link_up, receive_lane2, run;
    logic        tx_send_idle, tx_grant, deskew_adjust_en, column_mismatch;
    ssi_pkg::ssi_pins_s pins;
    int          fail_count, checked, ticks, t0;
    ssi_peer_model u_ssi_peer_model (.run(run), .k(cmd_k), .inv(cmd_inv), .a(cmd_a),
        .present(cmd_p), .pins(pins));
    ssi_link_init u_ssi_link_init (.mclk(mclk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cg_clk(pins.clk),
        .lane_k285(pins.k), .lane_invalid(pins.inv), .lane_align(pins.a),
        .input_present(pins.present), .tx_busy(tx_busy), .lane02_drv_oe(lane02_drv_oe),
        .lane13_drv_oe(lane13_drv_oe), .link_up(link_up), .receive_lane2(receive_lane2),
        .tx_send_idle(tx_send_idle), .tx_grant(tx_grant), .lane_realign_en(lane_realign_en),
        .deskew_adjust_en(deskew_adjust_en), .column_mismatch(column_mismatch));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dw);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dw;
        // only the watchdog ends a wait for ack
        do begin
            @(posedge mclk);
        end while (wb_ack_o !== 1'b1);
        rdata = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic st(input logic [31:0] exp, input string what);
        bus(1'b0, ssi_pkg::ADDR_STATUS, 32'h0);
        chk(what, exp, rdata);
    endtask
    // one column per code-group clock; clock halts afterwards
    task automatic send(input logic [3:0] k, input logic [3:0] inv, input logic [3:0] a, int n);
        run <= 1'b1;
        repeat (n) begin
            cmd_k <= k;
            cmd_inv <= inv;
            cmd_a <= a;
            @(posedge pins.clk);
        end
        run <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask
    task automatic wait_oe();
        t0 = ticks;
        while (lane02_drv_oe !== 1'b1 && ticks - t0 < 1500) @(posedge mclk);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // ticks advance on the falling edge so reads at rising edges never race
    always @(negedge mclk) ticks++;
    initial begin
        #2000000;
        fail_count++;
        close_out();
    end
    initial begin
        {resetn, wb_cyc_i, wb_stb_i, wb_we_i, run} = 5'h00;
        {wb_adr_i, wb_dat_i, cmd_k, cmd_inv, cmd_a} = '0;
        cmd_p = 4'hf;
        {wb_sel_i, tx_busy} = 5'h1f;
        {fail_count, checked, ticks} = '0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        chk("reset drivers", 32'h0, 32'({lane02_drv_oe, lane13_drv_oe}));
        chk("reset link", 32'h0, 32'({link_up, tx_grant}));
        chk("reset idle", 32'h1, 32'(tx_send_idle));
        chk("reset realign", 32'h1f, 32'({lane_realign_en, deskew_adjust_en}));
        bus(1'b0, 8'h08, 32'h0);
        chk("unmapped", 32'h0, rdata);
        bus(1'b1, ssi_pkg::ADDR_CTRL, 32'h2);
        bus(1'b0, ssi_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl", 32'h2, rdata);
        bus(1'b1, ssi_pkg::ADDR_CTRL, 32'h0);
        st(32'h0, "quiet status");
        $display("test registers done");
        while (lane02_drv_oe !== 1'b1 && ticks < 1500) @(posedge mclk);
        chk("quiet length", 32'h1, 32'(ticks >= 1198 && ticks <= 1210));
        st(32'h100, "seek status");
        send(4'hf, 4'h0, 4'h0, 20);
        send(4'h0, 4'hf, 4'h0, 1);
        send(4'hf, 4'h0, 4'h0, 127);
        st(32'h100, "lock early");
        send(4'hf, 4'h0, 4'h0, 1);
        st(32'h29f, "locked");
        chk("up link", 32'h3, 32'({link_up, tx_grant}));
        chk("up realign", 32'h1, 32'({lane_realign_en, deskew_adjust_en}));
        $display("test lock done");
        send(4'h0, 4'h0, 4'hf, 3);
        st(32'h29f, "three columns");
        send(4'h0, 4'h0, 4'hf, 1);
        st(32'h2bf, "aligned");
        chk("aligned adjust", 32'h0, 32'(deskew_adjust_en));
        send(4'h0, 4'h0, 4'h1, 1);
        st(32'h2ff, "one mismatch");
        chk("mismatch pin", 32'h1, 32'(column_mismatch));
        chk("mismatch adjust", 32'h0, 32'(deskew_adjust_en));
        send(4'h0, 4'h0, 4'hf, 4);
        st(32'h2bf, "realigned");
        chk("clean pin", 32'h0, 32'(column_mismatch));
        send(4'h0, 4'h0, 4'h1, 2);
        st(32'h2df, "two mismatches");
        chk("lost adjust", 32'h1, 32'(deskew_adjust_en));
        $display("test deskew done");
        send(4'h0, 4'h2, 4'h0, 1);
        send(4'h0, 4'h0, 4'h0, 255);
        send(4'h0, 4'h2, 4'h0, 2);
        st(32'h29f, "decrement");
        chk("error keeps lock", 32'h0, 32'(lane_realign_en));
        send(4'h0, 4'h2, 4'h0, 1);
        st(32'h28d, "lane 1 lost");
        chk("lane 1 realign", 32'h2, 32'(lane_realign_en));
        send(4'h0, 4'h1, 4'h0, 3);
        st(32'h00c, "link down");
        chk("down grant", 32'h1, 32'({link_up, tx_grant, tx_send_idle}));
        chk("down driver", 32'h0, 32'(lane02_drv_oe));
        $display("test errors done");
        cmd_p <= 4'h0;
        send(4'h3, 4'h0, 4'h0, 1);
        chk("absent refused", 32'h3, 32'(lane_realign_en));
        cmd_p <= 4'hf;
        send(4'h3, 4'h3, 4'h0, 1);
        chk("invalid refused", 32'h3, 32'(lane_realign_en));
        $display("test refuse done");
        wait_oe();
        repeat (10) @(posedge mclk);
        st(32'h68c, "lane 2 up");
        chk("lane 2 pin", 32'h1, 32'(receive_lane2));
        bus(1'b1, ssi_pkg::ADDR_CTRL, 32'h1);
        bus(1'b0, ssi_pkg::ADDR_CTRL, 32'h0);
        chk("request cleared", 32'h0, rdata);
        chk("restart", 32'h0, 32'({link_up, lane02_drv_oe}));
        st(32'h40c, "restart status");
        $display("test restart done");
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        chk("reset again", 32'h1f, 32'({lane_realign_en, deskew_adjust_en}));
        st(32'h0, "reset status");
        $display("test reset done");
        close_out();
    end
endmodule
bind ssi_link_init ssi_link_init_assertions u_ssi_link_init_assertions (.mclk(mclk),
    .resetn(resetn), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .tx_busy(tx_busy),
    .lane02_drv_oe(lane02_drv_oe), .lane13_drv_oe(lane13_drv_oe), .link_up(link_up),
    .receive_lane2(receive_lane2), .tx_send_idle(tx_send_idle), .tx_grant(tx_grant));
